// File: core/prc_periph_regs.sv
`timescale 1ns/1ps
module prc_periph_regs #(
  parameter int NUM_PORTS = 2,
  parameter int CNT_W     = 16
) (
  // clock and reset
  input  wire logic                               clk_sys,
  input  wire logic                               rstn,
  input  wire logic                               ce,
  // peripheral bus
  input  wire prc_pkg::prc_bus_req_type           bus_req,
  output logic [prc_pkg::DATA_W-1:0]              bus_rdata_ff,
  // transfer channels, index port*2 + (0 rx, 1 tx)
  input  wire logic [2*NUM_PORTS-1:0]             xfer_req,
  input  wire logic [2*NUM_PORTS-1:0]             xfer_done,
  output logic [2*NUM_PORTS-1:0]                  xfer_go,
  output logic [2*NUM_PORTS-1:0][prc_pkg::PTR_W-1:0] xfer_addr,
  // interrupt source per port
  output logic [NUM_PORTS-1:0]                    irq
);

  localparam int NCH = 2 * NUM_PORTS;

  // ==========================================================
  // elaboration checks
  if (NUM_PORTS < 1 || NUM_PORTS > prc_pkg::MAX_PORTS) begin : g_chk_p
    $error("prc_periph_regs: NUM_PORTS out of range");
  end
  if (CNT_W < 1 || CNT_W > prc_pkg::DATA_W) begin : g_chk_c
    $error("prc_periph_regs: CNT_W out of range");
  end
  // the port select must sit just above the per-port offset
  if (prc_pkg::OFS_W + 1 != prc_pkg::ADDR_W) begin : g_chk_a
    $error("prc_periph_regs: address split does not fit");
  end

  // ==========================================================
  // address decode; byte lanes dropped so any access acts on the word
  logic [prc_pkg::OFS_W-1:0] ofs;
  logic                      port_idx;
  logic                      wr_en;
  logic                      rd_en;
  logic [prc_pkg::DATA_W-1:0] wd;

  assign ofs      = {bus_req.addr[prc_pkg::OFS_W-1:2], 2'b00};
  assign port_idx = bus_req.addr[prc_pkg::OFS_W];
  assign wr_en    = ce & bus_req.sel & bus_req.wr;
  assign rd_en    = ce & bus_req.sel & ~bus_req.wr;
  assign wd       = bus_req.wdata;

  logic [NUM_PORTS-1:0][prc_pkg::DATA_W-1:0] rd_val;
  logic [NUM_PORTS-1:0]                      rd_hit;
  logic [NCH-1:0][prc_pkg::PTR_W-1:0]        ptr;
  logic [NCH-1:0][CNT_W-1:0]                 cnt;
  logic [NCH-1:0]                            ch_end;

  // ==========================================================
  // per serial port register set
  genvar p;
  genvar d;
  for (p = 0; p < NUM_PORTS; p++) begin : g_port
    logic [prc_pkg::MODE_W-1:0] mode_ff;
    logic [1:0]                 chen_ff;
    logic [prc_pkg::ST_W-1:0]   imask_ff;
    logic [prc_pkg::ST_W-1:0]   status;
    logic                       wp;
    logic                       wr_mode;
    logic                       wr_chen;
    logic                       wr_chdis;
    logic                       wr_ien;
    logic                       wr_idis;
    logic                       wr_cmd;
    logic [prc_pkg::DATA_W-1:0] rv;
    logic                       rh;

    assign wp       = wr_en & (32'(port_idx) == p);
    // one strobe per writable offset keeps the register processes short
    assign wr_mode  = wp & (ofs == prc_pkg::OFS_MODE);
    assign wr_chen  = wp & (ofs == prc_pkg::OFS_CHEN);
    assign wr_chdis = wp & (ofs == prc_pkg::OFS_CHDIS);
    assign wr_ien   = wp & (ofs == prc_pkg::OFS_IEN);
    assign wr_idis  = wp & (ofs == prc_pkg::OFS_IDIS);
    assign wr_cmd   = wp & (ofs == prc_pkg::OFS_CMD);

    // writes to the status offset have no decode and so no effect
    assign status = {chen_ff, ch_end[2*p+1], ch_end[2*p]};

    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        mode_ff <= prc_pkg::MODE_RST;
      end else if (wr_mode) begin
        mode_ff <= wd[prc_pkg::MODE_W-1:0];
      end
    end

    // enable and disable on one register pair; zero bits hold
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        chen_ff <= 2'h0;
      end else if (wr_chen) begin
        chen_ff <= chen_ff |
                   wd[prc_pkg::ST_TX_EN:prc_pkg::ST_RX_EN];
      end else if (wr_chdis) begin
        chen_ff <= chen_ff &
                   ~wd[prc_pkg::ST_TX_EN:prc_pkg::ST_RX_EN];
      end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        imask_ff <= prc_pkg::MASK_RST;
      end else if (wr_ien) begin
        imask_ff <= imask_ff | wd[prc_pkg::ST_W-1:0];
      end else if (wr_idis) begin
        imask_ff <= imask_ff & ~wd[prc_pkg::ST_W-1:0];
      end
    end

    // level source; stays high while a masked end flag stands
    assign irq[p] = |(status & imask_ff);

    // read mux; fields are zero-extended so unused bits read zero
    // write-only offsets fall to the default and so read zero
    always_comb begin
      rh = 1'b1;
      case (ofs)
        prc_pkg::OFS_MODE:  rv = 32'(mode_ff);
        prc_pkg::OFS_STAT:  rv = 32'(status);
        prc_pkg::OFS_IMASK: rv = 32'(imask_ff);
        prc_pkg::OFS_RPTR:  rv = ptr[2*p];
        prc_pkg::OFS_RCNT:  rv = 32'(cnt[2*p]);
        prc_pkg::OFS_TPTR:  rv = ptr[2*p+1];
        prc_pkg::OFS_TCNT:  rv = 32'(cnt[2*p+1]);
        default: begin
          rv = '0;
          rh = 1'b0;
        end
      endcase
    end

    assign rd_val[p] = rv;
    assign rd_hit[p] = rh;

    // ========================================================
    // the two channels owned by this port
    for (d = 0; d < 2; d++) begin : g_chan
      prc_pkg::prc_chan_wr_type cw;
      logic [prc_pkg::OFS_W-1:0] ofs_p;
      logic [prc_pkg::OFS_W-1:0] ofs_c;
      logic [1:0]                sz;

      // each direction reads its own size field of the mode register
      assign sz    = mode_ff[prc_pkg::MODE_RXSZ + 2*d +: 2];
      assign ofs_p = (d == 0) ? prc_pkg::OFS_RPTR : prc_pkg::OFS_TPTR;
      assign ofs_c = (d == 0) ? prc_pkg::OFS_RCNT : prc_pkg::OFS_TCNT;
      assign cw.wr_ptr = wp & (ofs == ofs_p);
      assign cw.wr_cnt = wp & (ofs == ofs_c);
      // command register: only a one in the bit acts
      assign cw.abort  = wr_cmd &
                         wd[prc_pkg::CMD_ABORT_RX + d];
      assign cw.wdata  = wd;

      prc_xfer_chan #(
        .CNT_W (CNT_W)
      ) u_chan (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .ce        (ce),
        .wr        (cw),
        .size      (sz),
        .run       (chen_ff[d]),
        .ptr_ff    (ptr[2*p+d]),
        .cnt_ff    (cnt[2*p+d]),
        .end_xfer  (ch_end[2*p+d]),
        .xfer_req  (xfer_req[2*p+d]),
        .xfer_done (xfer_done[2*p+d]),
        .xfer_go   (xfer_go[2*p+d])
      );

      assign xfer_addr[2*p+d] = ptr[2*p+d];
    end
  end

  // ==========================================================
  // registered read data; unmapped or write-only offsets read zero
  logic [prc_pkg::DATA_W-1:0] rd_sel;

  always_comb begin
    rd_sel = '0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (32'(port_idx) == i && rd_hit[i]) begin
        rd_sel = rd_val[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bus_rdata_ff <= '0;
    end else if (rd_en) begin
      bus_rdata_ff <= rd_sel;
    end
  end

endmodule

// File: core/prc_pkg.sv
package prc_pkg;

  // ==========================================================
  // bus geometry
  localparam int ADDR_W    = 15;
  localparam int DATA_W    = 32;
  localparam int OFS_W     = 14;
  localparam int PTR_W     = 32;
  localparam int CNT_W     = 16;
  localparam int MAX_PORTS = 2;

  // ==========================================================
  // register offsets inside one serial port's space
  localparam logic [OFS_W-1:0] OFS_CMD   = 14'h0000;
  localparam logic [OFS_W-1:0] OFS_MODE  = 14'h0004;
  localparam logic [OFS_W-1:0] OFS_CHEN  = 14'h0008;
  localparam logic [OFS_W-1:0] OFS_CHDIS = 14'h000c;
  localparam logic [OFS_W-1:0] OFS_STAT  = 14'h0010;
  localparam logic [OFS_W-1:0] OFS_IEN   = 14'h0014;
  localparam logic [OFS_W-1:0] OFS_IDIS  = 14'h0018;
  localparam logic [OFS_W-1:0] OFS_IMASK = 14'h001c;
  localparam logic [OFS_W-1:0] OFS_RPTR  = 14'h0030;
  localparam logic [OFS_W-1:0] OFS_RCNT  = 14'h0034;
  localparam logic [OFS_W-1:0] OFS_TPTR  = 14'h0038;
  localparam logic [OFS_W-1:0] OFS_TCNT  = 14'h003c;

  // ==========================================================
  // status / mask field positions
  localparam int ST_END_RX = 0;
  localparam int ST_END_TX = 1;
  localparam int ST_RX_EN  = 2;
  localparam int ST_TX_EN  = 3;
  localparam int ST_W      = 4;

  // command bits
  localparam int CMD_ABORT_RX = 0;
  localparam int CMD_ABORT_TX = 1;

  // mode register
  localparam int              MODE_W       = 4;
  localparam int              MODE_RXSZ    = 0;
  localparam int              MODE_TXSZ    = 2;
  localparam logic [MODE_W-1:0] MODE_RST   = 4'h0;

  // transfer size codes and reset values
  localparam logic [1:0]       SZ_BYTE  = 2'h0;
  localparam logic [1:0]       SZ_HALF  = 2'h1;
  localparam logic [PTR_W-1:0] STEP_B   = 32'h0000_0001;
  localparam logic [PTR_W-1:0] STEP_H   = 32'h0000_0002;
  localparam logic [PTR_W-1:0] STEP_W   = 32'h0000_0004;
  localparam logic [PTR_W-1:0] PTR_RST  = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_RST  = 16'h0000;
  localparam logic [ST_W-1:0]  MASK_RST = 4'h0;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic              sel;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } prc_bus_req_type;

  typedef struct packed {
    logic             wr_ptr;
    logic             wr_cnt;
    logic             abort;
    logic [PTR_W-1:0] wdata;
  } prc_chan_wr_type;

endpackage

// File: core/prc_xfer_chan.sv
`timescale 1ns/1ps
module prc_xfer_chan #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rstn,
  input  wire logic                       ce,
  // register side
  input  wire prc_pkg::prc_chan_wr_type   wr,
  input  wire logic [1:0]                 size,
  input  wire logic                       run,
  output logic [prc_pkg::PTR_W-1:0]       ptr_ff,
  output logic [CNT_W-1:0]                cnt_ff,
  output logic                            end_xfer,
  // transfer side
  input  wire logic                       xfer_req,
  input  wire logic                       xfer_done,
  output logic                            xfer_go
);

  // ==========================================================
  // step and handshake
  logic [prc_pkg::PTR_W-1:0] step;
  logic                      active;
  logic                      advance;

  always_comb begin
    case (size)
      prc_pkg::SZ_BYTE: step = prc_pkg::STEP_B;
      prc_pkg::SZ_HALF: step = prc_pkg::STEP_H;
      default:          step = prc_pkg::STEP_W;
    endcase
  end

  // a zero count means the channel is idle, so requests are ignored
  assign active   = run & (cnt_ff != '0);
  assign xfer_go  = xfer_req & active;
  assign advance  = xfer_done & active;
  assign end_xfer = (cnt_ff == '0);

  // ==========================================================
  // pointer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ptr_ff <= prc_pkg::PTR_RST;
    end else if (ce) begin
      if (wr.wr_ptr) begin
        ptr_ff <= wr.wdata;
      end else if (advance) begin
        ptr_ff <= ptr_ff + step;
      end
    end
  end

  // ==========================================================
  // counter; a software write beats a completing transfer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= CNT_W'(prc_pkg::CNT_RST);
    end else if (ce) begin
      if (wr.abort) begin
        cnt_ff <= '0;
      end else if (wr.wr_cnt) begin
        cnt_ff <= wr.wdata[CNT_W-1:0];
      end else if (advance) begin
        cnt_ff <= cnt_ff - CNT_W'(1);
      end
    end
  end

endmodule

// File: verification/prc_periph_regs_props.sv
`timescale 1ns/1ps
// ==========================================================
// port checks
module prc_periph_regs_props #(
  parameter int NUM_PORTS = 2,
  parameter int CNT_W     = 16
) (
  // bus
  input wire logic                         clk_sys,
  input wire logic                         rstn,
  input wire logic                         ce,
  input wire prc_pkg::prc_bus_req_type     bus_req,
  input wire logic [31:0]                  bus_rdata_ff,
  // channels
  input wire logic [2*NUM_PORTS-1:0]       xfer_req,
  input wire logic [2*NUM_PORTS-1:0]       xfer_done,
  input wire logic [2*NUM_PORTS-1:0]       xfer_go,
  input wire logic [2*NUM_PORTS-1:0][31:0] xfer_addr,
  input wire logic [NUM_PORTS-1:0]         irq
);
  logic       rd;
  logic       wt;
  logic [3:0] w;
  assign rd = ce && bus_req.sel && !bus_req.wr;
  assign wt = ce && bus_req.sel && bus_req.wr;
  // offsets past the first sixteen words fold to an unused one
  assign w = bus_req.addr[13:6] == 8'h0 ? bus_req.addr[5:2] : 4'h8;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  go_req_a: assert property (!(|(xfer_go & ~xfer_req)))
    else $error("go without request");
  rdata_hold_a: assert property (!rd |=> $stable(bus_rdata_ff))
    else $error("read data moved");
  cmd_zero_a: assert property
    (rd && w == 4'h0 |=> bus_rdata_ff == 32'h0)
    else $error("command read not zero");
  chen_zero_a: assert property
    (rd && w == 4'h2 |=> bus_rdata_ff == 32'h0)
    else $error("enable read not zero");
  stat_pad_a: assert property
    (rd && w == 4'h4 |=> bus_rdata_ff[31:4] == 28'h0)
    else $error("status spare bits set");
  ptr_step_a: assert property
    (xfer_done[0] && xfer_go[0] && ce && !wt |=>
      (xfer_addr[0] - $past(xfer_addr[0])) inside {1, 2, 4})
    else $error("bad pointer step");
  ptr_hold_a: assert property
    (!xfer_done[0] && !wt |=> $stable(xfer_addr[0]))
    else $error("pointer moved alone");
  irq_cause_a: assert property
    (ce && !wt && !(|xfer_done) |=> $stable(irq))
    else $error("interrupt moved alone");
  cover property (xfer_done[0] && xfer_go[0]);
  cover property ($rose(irq[0]));
  cover property (rd && w == 4'h4);
endmodule

// File: verification/prc_periph_regs_test.sv
`timescale 1ns/1ps
bind prc_periph_regs prc_periph_regs_props #(.NUM_PORTS(NUM_PORTS),
  .CNT_W(CNT_W)) props (.clk_sys, .rstn, .ce, .bus_req, .bus_rdata_ff,
  .xfer_req, .xfer_done, .xfer_go, .xfer_addr, .irq);
// ==========================================================
// bench
module prc_periph_regs_test;
  logic                     clk_sys = 1'b0;
  logic                     rstn = 1'b0;
  logic                     ce = 1'b0;
  logic                     slow = 1'b0;
  logic [3:0]               want = 4'h0;
  prc_pkg::prc_bus_req_type bus_req = '0;
  logic [31:0]              bus_rdata_ff, m_rd;
  logic [3:0]               xfer_req, xfer_done, xfer_go;
  logic [3:0][31:0]         xfer_addr;
  logic [1:0]               irq;
  logic [31:0]              m_ptr [4];
  logic [15:0]              m_cnt [4];
  logic [3:0]               m_mode [2], m_mask [2];
  logic [1:0]               m_en [2];
  int                       n_fail = 0, n_checks = 0, cyc = 0;
  int                       seed = 32'h94b2;
  logic [31:0]              msk [16] = '{32'h3, 32'hf, 32'hc, 32'hc,
    32'hf, 32'hf, 32'hf, 32'hf, 32'h0, 32'h0, 32'h0, 32'h0,
    32'hffffffff, 32'hffff, 32'hffffffff, 32'hffff};
  always #5 clk_sys = ~clk_sys;
  prc_periph_regs #(.NUM_PORTS(2), .CNT_W(16)) dut (.clk_sys, .rstn, .ce,
    .bus_req, .bus_rdata_ff, .xfer_req, .xfer_done, .xfer_go, .xfer_addr,
    .irq);
  prc_xfer_peer peer (.clk_sys, .rstn, .want, .slow, .xfer_go, .xfer_req,
    .xfer_done);
  function automatic logic [3:0] stat(int p);
    return {m_en[p], m_cnt[2*p+1] == 16'h0, m_cnt[2*p] == 16'h0};
  endfunction
  function automatic logic [31:0] rdv(int p, logic [3:0] w);
    case (w)
      4'h1: return {28'h0, m_mode[p]};
      4'h4: return {28'h0, stat(p)};
      4'h7: return {28'h0, m_mask[p]};
      4'hc: return m_ptr[2*p];
      4'hd: return {16'h0, m_cnt[2*p]};
      4'he: return m_ptr[2*p+1];
      4'hf: return {16'h0, m_cnt[2*p+1]};
      default: return 32'h0;
    endcase
  endfunction
  // ==========================================================
  // reference model: transfers use the values from before the edge
  always @(posedge clk_sys or negedge rstn) begin : model
    int          p;
    logic [3:0]  w;
    logic [31:0] d;
    logic [1:0]  sz;
    if (!rstn) begin
      m_ptr = '{default: 32'h0};
      m_cnt = '{default: 16'h0};
      m_mode = '{default: 4'h0};
      m_mask = '{default: 4'h0};
      m_en = '{default: 2'h0};
      m_rd = 32'h0;
    end else if (ce) begin
      p = bus_req.addr[14];
      w = bus_req.addr[13:6] == 8'h0 ? bus_req.addr[5:2] : 4'h8;
      d = bus_req.wdata;
      if (bus_req.sel && !bus_req.wr) m_rd = rdv(p, w);
      for (int c = 0; c < 4; c++) begin
        sz = m_mode[c/2][2*(c%2) +: 2];
        if (xfer_done[c] && xfer_req[c] && m_en[c/2][c%2]
            && m_cnt[c] != 16'h0) begin
          m_ptr[c] += sz == 2'h0 ? 32'h1 : sz == 2'h1 ? 32'h2 : 32'h4;
          m_cnt[c] -= 16'h1;
        end
      end
      if (bus_req.sel && bus_req.wr) begin
        case (w)
          4'h0: begin
            if (d[0]) m_cnt[2*p] = 16'h0;
            if (d[1]) m_cnt[2*p+1] = 16'h0;
          end
          4'h1: m_mode[p] = d[3:0];
          4'h2: m_en[p] |= d[3:2];
          4'h3: m_en[p] &= ~d[3:2];
          4'h5: m_mask[p] |= d[3:0];
          4'h6: m_mask[p] &= ~d[3:0];
          4'hc: m_ptr[2*p] = d;
          4'hd: m_cnt[2*p] = d[15:0];
          4'he: m_ptr[2*p+1] = d;
          4'hf: m_cnt[2*p+1] = d[15:0];
          default: ;
        endcase
      end
    end
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // the request is held until the next falling edge
  task automatic acc(logic w, logic [14:0] a, logic [31:0] d);
    @(negedge clk_sys);
    bus_req = '{1'b1, w, a, d};
  endtask
  task automatic idle();
    @(negedge clk_sys);
    bus_req = '0;
  endtask
  task automatic rnd(logic [3:0] lo);
    logic [3:0] o;
    o = 4'($random(seed));
    if (o < lo) o = o + lo;
    acc(1'($random(seed)), {1'($random(seed)), 8'h0, o, 2'($random(seed))},
      $random(seed) & msk[o]);
  endtask
  // ==========================================================
  // results settle for 1 ns after the falling edge
  always begin
    @(negedge clk_sys);
    #1;
    cyc++;
    if (cyc > 5000) begin
      n_fail++;
      conclude();
    end
    if (rstn) begin
      chk("read data", m_rd, bus_rdata_ff);
      for (int c = 0; c < 4; c++) begin
        chk("pointer", m_ptr[c], xfer_addr[c]);
        chk("go", xfer_req[c] && m_en[c/2][c%2] && m_cnt[c] != 16'h0,
          xfer_go[c]);
      end
      for (int p = 0; p < 2; p++)
        chk("interrupt", |(stat(p) & m_mask[p]), irq[p]);
    end
  end
  initial begin
    repeat (20) @(negedge clk_sys);
    rstn = 1'b1;
    ce = 1'b1;
    for (int i = 0; i < 32; i++)
      acc(1'b0, {i[4], 8'h0, i[3:0], 2'b00}, 32'h0);
    idle();
    $display("reset value test done");
    repeat (80) rnd(4'h0);
    idle();
    $display("register access test done");
    for (int r = 0; r < 2; r++) begin
      slow = r[0];
      for (int p = 0; p < 2; p++) begin
        acc(1'b1, {p[0], 14'h4}, 32'($random(seed)) & 32'hf);
        acc(1'b1, {p[0], 14'h34}, 32'h1 + (32'($random(seed)) & 32'h7));
        acc(1'b1, {p[0], 14'h3c}, 32'h1 + (32'($random(seed)) & 32'h7));
        acc(1'b1, {p[0], 14'h8}, 32'hc);
        acc(1'b1, {p[0], 14'h14}, 32'h3);
      end
      want = 4'hf;
      repeat (200) begin
        ce = $random(seed) % 8 != 0;
        if ($random(seed) % 2)
          rnd(4'h4);
        else
          idle();
      end
      ce = 1'b1;
      want = 4'h0;
      repeat (3) idle();
      acc(1'b1, 15'h0, 32'h3);
      acc(1'b1, 15'h400c, 32'hc);
      acc(1'b0, 15'h4010, 32'h0);
      idle();
      $display("transfer round %0d done", r);
    end
    conclude();
  end
endmodule

// File: verification/prc_xfer_peer.sv
`timescale 1ns/1ps
// ==========================================================
// far side of the four channels
module prc_xfer_peer (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // bench control
  input  wire logic [3:0] want,
  input  wire logic       slow,
  // handshake
  input  wire logic [3:0] xfer_go,
  output logic      [3:0] xfer_req,
  output logic      [3:0] xfer_done
);
  logic [7:0] lfsr_ff;
  // a slow peer skips a random share of the cycles it could use
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lfsr_ff   <= 8'h5b;
      xfer_done <= 4'h0;
    end else begin
      lfsr_ff   <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5]};
      xfer_done <= xfer_go & want & ~({4{slow}} & lfsr_ff[3:0]);
    end
  end
  // request stays up while a done is out, so none goes unclaimed
  assign xfer_req = want | xfer_done;
endmodule
